//--- rtl/dpsf_host.sv
// Purpose: port-side controller for eight hardware token flags
// Assumes: the far device keeps its own flag logic; pins are synchronous
// Notes: releases every flag once after reset before taking commands
`timescale 1ns/10ps
module dpsf_host #(
   parameter int ADDR_W = dpsf_pkg::DPSF_ADDR_W,
   parameter int MAX_POLLS = dpsf_pkg::DPSF_MAX_POLLS
) (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic cmd_valid_in,
   input dpsf_pkg::dpsf_cmd_t cmd_in,
   output logic cmd_ready_out,
   output logic rsp_valid_out,
   output dpsf_pkg::dpsf_rsp_t rsp_out,
   output logic ce_n_out,
   output logic token_space_select_n_out,
   output logic oe_n_out,
   output logic rw_n_out,
   output logic [ADDR_W-1:0] addr_out,
   output logic [dpsf_pkg::DPSF_DATA_W-1:0] data_out,
   output logic data_oe_out,
   input wire logic [dpsf_pkg::DPSF_DATA_W-1:0] data_in
);
   import dpsf_pkg::*;

   typedef enum logic [2:0] {
      H_BOOT, H_IDLE, H_WAIT, H_ACQ_READ, H_ACQ_EVAL, H_INIT_NEXT, H_RESP
   } dpsf_host_state_t;

   dpsf_host_state_t state_reg, state_next, after_reg, after_next;
   dpsf_cmd_t cmd_reg, cmd_next;
   dpsf_rsp_t rsp_reg, rsp_next;
   dpsf_pins_t pins;
   logic start_reg, start_next;
   logic wr_reg, wr_next;
   logic bit_reg, bit_next;
   logic [DPSF_IDX_W-1:0] idx_reg, idx_next;
   logic [DPSF_CNT_W-1:0] polls_reg, polls_next;
   logic boot_reg, boot_next;
   logic ready_reg, ready_next;
   logic rsp_valid_reg, rsp_valid_next;
   logic cyc_done;
   logic cyc_rbit;

   // one pin-level access at a time; the sequencer owns every pin flop
   dpsf_cycle u_cycle (
      .sys_clk_in(sys_clk_in),
      .sys_rst_in(sys_rst_in),
      .start_in(start_reg),
      .write_in(wr_reg),
      .idx_in(idx_reg),
      .bit_in(bit_reg),
      .data_in(data_in),
      .pins_out(pins),
      .done_out(cyc_done),
      .rbit_out(cyc_rbit)
   );

   // command sequencer: each access is issued, then H_WAIT returns to after_reg
   always_comb begin
      state_next = state_reg;
      after_next = after_reg;
      cmd_next = cmd_reg;
      rsp_next = rsp_reg;
      wr_next = wr_reg;
      bit_next = bit_reg;
      idx_next = idx_reg;
      polls_next = polls_reg;
      boot_next = boot_reg;
      ready_next = ready_reg;
      start_next = 1'b0;
      rsp_valid_next = 1'b0;
      case (state_reg)
         H_BOOT: begin
            // flags come up in no known state, so free them all from here
            idx_next = '0;
            wr_next = 1'b1;
            bit_next = DPSF_FLAG_FREE;
            start_next = 1'b1;
            after_next = H_INIT_NEXT;
            state_next = H_WAIT;
         end
         H_IDLE: begin
            if (cmd_valid_in && ready_reg) begin
               ready_next = 1'b0;
               cmd_next = cmd_in;
               idx_next = cmd_in.idx;
               polls_next = '0;
               rsp_next = '0;
               start_next = 1'b1;
               state_next = H_WAIT;
               wr_next = 1'b1;
               bit_next = DPSF_FLAG_FREE;
               case (cmd_in.op)
                  DPSF_OP_ACQUIRE: begin
                     bit_next = DPSF_FLAG_REQ;
                     after_next = H_ACQ_READ;
                  end
                  DPSF_OP_RELEASE: begin
                     after_next = H_RESP;
                  end
                  DPSF_OP_INIT: begin
                     idx_next = '0;
                     after_next = H_INIT_NEXT;
                  end
                  default: begin
                     wr_next = 1'b0;
                     after_next = H_RESP;
                  end
               endcase
            end
         end
         H_WAIT: begin
            if (cyc_done) begin
               state_next = after_reg;
            end
         end
         H_ACQ_READ: begin
            // read back only after the request is written
            wr_next = 1'b0;
            start_next = 1'b1;
            after_next = H_ACQ_EVAL;
            state_next = H_WAIT;
         end
         H_ACQ_EVAL: begin
            rsp_next.flag = cyc_rbit;
            if (cyc_rbit == DPSF_FLAG_REQ) begin
               rsp_next.granted = 1'b1;
               state_next = H_RESP;
            end else if (polls_reg < DPSF_CNT_W'(MAX_POLLS)) begin
               // a fresh access per poll, since the read value is latched
               polls_next = polls_reg + 1'b1;
               wr_next = 1'b0;
               start_next = 1'b1;
               after_next = H_ACQ_EVAL;
               state_next = H_WAIT;
            end else begin
               // give up and withdraw, a stale request could hang the other side
               rsp_next.withdrawn = 1'b1;
               wr_next = 1'b1;
               bit_next = DPSF_FLAG_FREE;
               start_next = 1'b1;
               after_next = H_RESP;
               state_next = H_WAIT;
            end
         end
         H_INIT_NEXT: begin
            if (idx_reg == DPSF_IDX_W'(DPSF_FLAGS - 1)) begin
               if (boot_reg) begin
                  boot_next = 1'b0;
                  ready_next = 1'b1;
                  state_next = H_IDLE;
               end else begin
                  state_next = H_RESP;
               end
            end else begin
               idx_next = idx_reg + 1'b1;
               wr_next = 1'b1;
               bit_next = DPSF_FLAG_FREE;
               start_next = 1'b1;
               after_next = H_INIT_NEXT;
               state_next = H_WAIT;
            end
         end
         H_RESP: begin
            if (cmd_reg.op == DPSF_OP_PEEK) begin
               rsp_next.flag = cyc_rbit;
            end
            rsp_valid_next = 1'b1;
            ready_next = 1'b1;
            state_next = H_IDLE;
         end
         default: begin
            state_next = H_IDLE;
            ready_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state_reg <= H_BOOT;
         after_reg <= H_IDLE;
         cmd_reg <= '0;
         rsp_reg <= '0;
         wr_reg <= 1'b0;
         bit_reg <= DPSF_FLAG_FREE;
         idx_reg <= '0;
         polls_reg <= '0;
         boot_reg <= 1'b1;
         ready_reg <= 1'b0;
         start_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         after_reg <= after_next;
         cmd_reg <= cmd_next;
         rsp_reg <= rsp_next;
         wr_reg <= wr_next;
         bit_reg <= bit_next;
         idx_reg <= idx_next;
         polls_reg <= polls_next;
         boot_reg <= boot_next;
         ready_reg <= ready_next;
         start_reg <= start_next;
         rsp_valid_reg <= rsp_valid_next;
      end
   end

   // pins straight from the sequencer flops; upper address bits are held low
   assign ce_n_out = pins.ce_n;
   assign token_space_select_n_out = pins.sel_n;
   assign oe_n_out = pins.oe_n;
   assign rw_n_out = pins.rw_n;
   assign addr_out = {{(ADDR_W - DPSF_IDX_W){1'b0}}, pins.idx};
   assign data_out = pins.dout;
   assign data_oe_out = pins.doe;
   assign cmd_ready_out = ready_reg;
   assign rsp_valid_out = rsp_valid_reg;
   assign rsp_out = rsp_reg;

   // helper state read only by the checks below
   logic last_wbit_reg, last_wbit_next;
   logic [DPSF_FLAGS-1:0] init_ones_reg, init_ones_next;
   always_comb begin
      last_wbit_next = last_wbit_reg;
      init_ones_next = init_ones_reg;
      if (!rw_n_out) begin
         last_wbit_next = data_out[0];
         if (boot_reg && data_out[0]) begin
            init_ones_next[pins.idx] = 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         last_wbit_reg <= DPSF_FLAG_FREE;
         init_ones_reg <= '0;
      end else begin
         last_wbit_reg <= last_wbit_next;
         init_ones_reg <= init_ones_next;
      end
   end

   AST_CE_OFF_IN_TOKEN_SPACE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !token_space_select_n_out |-> ce_n_out) else $error("memory enable active in token space");
   AST_STROBE_UNDER_SELECT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      (!oe_n_out || !rw_n_out) |-> !token_space_select_n_out && $stable(addr_out))
      else $error("strobe without token select or address moved");
   AST_WRITE_STROBE_LEN: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      $fell(rw_n_out) |-> (!rw_n_out && data_oe_out)[*3] ##1 rw_n_out)
      else $error("write strobe length wrong");
   AST_NO_DRIVE_ON_READ: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      !oe_n_out |-> !data_oe_out) else $error("data driven during read");
   AST_POLL_RELEASES_SELECT: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      $rose(oe_n_out) |-> token_space_select_n_out ##1 token_space_select_n_out)
      else $error("select held across reads");
   AST_WRITE_BEFORE_READ: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      $fell(oe_n_out) && cmd_reg.op == DPSF_OP_ACQUIRE && !boot_reg |-> !last_wbit_reg)
      else $error("acquire read without prior zero write");
   AST_FAILED_WITHDRAWN: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      rsp_valid_out && cmd_reg.op == DPSF_OP_ACQUIRE && !rsp_out.granted
      |-> rsp_out.withdrawn && last_wbit_reg) else $error("failed request left pending");
   AST_INIT_ALL_FREE: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
      $fell(boot_reg) |-> init_ones_reg == {DPSF_FLAGS{1'b1}} && cmd_ready_out)
      else $error("boot ended without freeing every flag");
endmodule : dpsf_host

//--- common/dpsf_pkg.sv
// Purpose: shared constants and carriers for the semaphore port controller
// Assumes: one port of a dual-port part with eight token flags, 100 MHz clock
// Notes: timing figures are conservative least times, rounded up to cycles
package dpsf_pkg;
   localparam int DPSF_FLAGS = 8;
   localparam int DPSF_IDX_W = 3;
   localparam int DPSF_DATA_W = 9;
   localparam int DPSF_ADDR_W = 14;
   localparam int DPSF_CNT_W = 4;
   localparam int DPSF_MAX_POLLS = 4;
   localparam int DPSF_PERIOD_NS = 10;
   // least times of one access, in ns
   localparam int DPSF_T_SETUP_NS = 10;
   localparam int DPSF_T_STROBE_NS = 30;
   localparam int DPSF_T_GAP_NS = 20;
   localparam int DPSF_SETUP_CYC = (DPSF_T_SETUP_NS + DPSF_PERIOD_NS - 1) / DPSF_PERIOD_NS;
   localparam int DPSF_STROBE_CYC = (DPSF_T_STROBE_NS + DPSF_PERIOD_NS - 1) / DPSF_PERIOD_NS;
   localparam int DPSF_GAP_CYC = (DPSF_T_GAP_NS + DPSF_PERIOD_NS - 1) / DPSF_PERIOD_NS;
   // flag levels: tokens are active low
   localparam logic DPSF_FLAG_REQ = 1'b0;
   localparam logic DPSF_FLAG_FREE = 1'b1;
   localparam logic DPSF_PIN_ON = 1'b0;
   localparam logic DPSF_PIN_OFF = 1'b1;

   typedef enum logic [1:0] {
      DPSF_OP_ACQUIRE,
      DPSF_OP_RELEASE,
      DPSF_OP_INIT,
      DPSF_OP_PEEK
   } dpsf_op_t;

   typedef struct packed {
      dpsf_op_t op;
      logic [DPSF_IDX_W-1:0] idx;
   } dpsf_cmd_t;

   typedef struct packed {
      logic granted;
      logic flag;
      logic withdrawn;
   } dpsf_rsp_t;

   typedef struct packed {
      logic ce_n;
      logic sel_n;
      logic oe_n;
      logic rw_n;
      logic [DPSF_IDX_W-1:0] idx;
      logic [DPSF_DATA_W-1:0] dout;
      logic doe;
   } dpsf_pins_t;

   localparam dpsf_pins_t DPSF_PINS_IDLE = '{ce_n: DPSF_PIN_OFF, sel_n: DPSF_PIN_OFF,
      oe_n: DPSF_PIN_OFF, rw_n: DPSF_PIN_OFF, idx: '0, dout: '0, doe: 1'b0};
endpackage : dpsf_pkg

//--- rtl/dpsf_cycle.sv
// Purpose: one static-RAM style access to the token space, read or write
// Assumes: start_in only while idle; data_in synchronous to sys_clk_in
// Notes: select drops with the strobe so back-to-back reads re-latch
`timescale 1ns/10ps
module dpsf_cycle (
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic start_in,
   input wire logic write_in,
   input wire logic [dpsf_pkg::DPSF_IDX_W-1:0] idx_in,
   input wire logic bit_in,
   input wire logic [dpsf_pkg::DPSF_DATA_W-1:0] data_in,
   output dpsf_pkg::dpsf_pins_t pins_out,
   output logic done_out,
   output logic rbit_out
);
   import dpsf_pkg::*;

   typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_GAP} dpsf_cy_state_t;

   dpsf_cy_state_t state_reg, state_next;
   logic [DPSF_CNT_W-1:0] cnt_reg, cnt_next;
   dpsf_pins_t pins_reg, pins_next;
   logic wr_reg, wr_next;
   logic rbit_reg, rbit_next;
   logic done_reg, done_next;

   // access sequencer: setup, strobe, then a gap with select released
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      pins_next = pins_reg;
      wr_next = wr_reg;
      rbit_next = rbit_reg;
      done_next = 1'b0;
      case (state_reg)
         CY_IDLE: begin
            if (start_in) begin
               pins_next.sel_n = DPSF_PIN_ON;
               pins_next.idx = idx_in;
               pins_next.dout = {DPSF_DATA_W{bit_in}};
               pins_next.doe = write_in;
               wr_next = write_in;
               cnt_next = DPSF_CNT_W'(DPSF_SETUP_CYC - 1);
               state_next = CY_SETUP;
            end
         end
         CY_SETUP: begin
            if (cnt_reg == '0) begin
               if (wr_reg) begin
                  pins_next.rw_n = DPSF_PIN_ON;
               end else begin
                  pins_next.oe_n = DPSF_PIN_ON;
               end
               cnt_next = DPSF_CNT_W'(DPSF_STROBE_CYC - 1);
               state_next = CY_STROBE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         CY_STROBE: begin
            if (cnt_reg == '0) begin
               // the flag is spread on every line; bit 0 is enough
               if (!wr_reg) begin
                  rbit_next = data_in[0];
               end
               pins_next.rw_n = DPSF_PIN_OFF;
               pins_next.oe_n = DPSF_PIN_OFF;
               pins_next.sel_n = DPSF_PIN_OFF;
               cnt_next = DPSF_CNT_W'(DPSF_GAP_CYC - 1);
               state_next = CY_GAP;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         CY_GAP: begin
            // data held through the gap to give the write its hold time
            if (cnt_reg == '0) begin
               pins_next.doe = 1'b0;
               done_next = 1'b1;
               state_next = CY_IDLE;
            end else begin
               cnt_next = cnt_reg - 1'b1;
            end
         end
         default: begin
            state_next = CY_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (sys_rst_in) begin
         state_reg <= CY_IDLE;
         cnt_reg <= '0;
         pins_reg <= DPSF_PINS_IDLE;
         wr_reg <= 1'b0;
         rbit_reg <= DPSF_FLAG_FREE;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         pins_reg <= pins_next;
         wr_reg <= wr_next;
         rbit_reg <= rbit_next;
         done_reg <= done_next;
      end
   end

   assign pins_out = pins_reg;
   assign done_out = done_reg;
   assign rbit_out = rbit_reg;
endmodule : dpsf_cycle

//--- tb/dpsf_dev_model.sv
// Purpose: two-port token flag device facing the controller
// Assumes: pins sampled on sys_clk_in; port b worked by the bench
// Notes: latches start from parameters, not free, after power-up
`timescale 1ns/10ps
module dpsf_dev_model #(
   parameter logic [7:0] INIT_REQ_A = 8'h5a,
   parameter logic [7:0] INIT_REQ_B = 8'h3c
) (
   input wire logic sys_clk_in,
   input wire logic a_ce_n_in,
   input wire logic a_sel_n_in,
   input wire logic a_oe_n_in,
   input wire logic a_rw_n_in,
   input wire logic [dpsf_pkg::DPSF_ADDR_W-1:0] a_addr_in,
   input wire logic [8:0] a_data_in,
   output logic [8:0] a_data_out,
   input wire logic b_sel_n_in,
   input wire logic b_oe_n_in,
   input wire logic b_rw_n_in,
   input wire logic [2:0] b_idx_in,
   input wire logic [8:0] b_data_in,
   output logic [8:0] b_data_out
);
   // request latches, never cleared at power-up
   logic [7:0] req_a = INIT_REQ_A;
   logic [7:0] req_b = INIT_REQ_B;
   logic [1:0] own [8]; // 0 free, 1 port a, 2 port b
   logic lat_a = 1'b1, lat_b = 1'b1, act_a = 1'b0, act_b = 1'b0;
   logic [8:0] pat = 9'h0a5;
   wire [2:0] ia = a_addr_in[2:0];
   wire wr_a = a_ce_n_in & !a_sel_n_in & !a_rw_n_in;
   wire rd_a = a_ce_n_in & !a_sel_n_in & !a_oe_n_in & a_rw_n_in;
   wire wr_b = !b_sel_n_in & !b_rw_n_in;
   wire rd_b = !b_sel_n_in & !b_oe_n_in & b_rw_n_in;
   initial begin
      for (int i = 0; i < 8; i++) own[i] = !INIT_REQ_A[i] ? 2'd1 : (!INIT_REQ_B[i] ? 2'd2 : 2'd0);
   end
   // writes only touch a latch; ownership follows from the latches
   always @(posedge sys_clk_in) begin
      if (wr_a) req_a[ia] = a_data_in[0];
      if (wr_b) req_b[b_idx_in] = b_data_in[0];
      for (int i = 0; i < 8; i++) begin
         if (own[i] == 2'd1 && req_a[i]) own[i] = req_b[i] ? 2'd0 : 2'd2;
         else if (own[i] == 2'd2 && req_b[i]) own[i] = req_a[i] ? 2'd0 : 2'd1;
         // a wins a same-edge tie
         if (own[i] == 2'd0) own[i] = !req_a[i] ? 2'd1 : (!req_b[i] ? 2'd2 : 2'd0);
      end
      // read value frozen while select and enable stay active
      if (rd_a && !act_a) lat_a <= (own[ia] != 2'd1);
      if (rd_b && !act_b) lat_b <= (own[b_idx_in] != 2'd2);
      act_a <= rd_a;
      act_b <= rd_b;
      pat <= ~pat;
   end
   // undriven lines show a changing pattern, never the last value
   assign a_data_out = rd_a ? {9{lat_a}} : pat;
   assign b_data_out = rd_b ? {9{lat_b}} : ~pat;
endmodule : dpsf_dev_model

//--- tb/tb_dpsf_host.sv
// Purpose: self-checking bench for the token flag port controller
// Assumes: the far port of the device is worked by this bench
// Notes: a reference of latches and owners predicts every answer but the contested grants
`timescale 1ns/10ps
module tb_dpsf_host;
   import dpsf_pkg::*;
   localparam logic [7:0] INIT_A = 8'h5a;
   localparam logic [7:0] INIT_B = 8'h3c;
   logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, cmd_valid_in = 1'b0;
   dpsf_cmd_t cmd_in = '0;
   logic cmd_ready_out, rsp_valid_out, ce_n, sel_n, oe_n, rw_n, data_oe;
   dpsf_rsp_t rsp_out, got;
   logic [DPSF_ADDR_W-1:0] addr;
   logic [8:0] data_out, dev_data, data_in, b_rdata, b_got;
   logic b_sel_n = 1'b1, b_oe_n = 1'b1, b_rw_n = 1'b1;
   logic [2:0] b_idx = '0;
   logic [8:0] b_wdata = '0;
   int errors = 0, cmp_count = 0, f;
   int own [8]; // 0 free, 1 controller, 2 bench port
   bit req_a [8], req_b [8], g;
   always #5 sys_clk_in = ~sys_clk_in;
   assign data_in = data_oe ? data_out : dev_data;
   dpsf_host #(.MAX_POLLS(2)) dpsf_host_inst (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
      .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
      .rsp_valid_out(rsp_valid_out), .rsp_out(rsp_out), .ce_n_out(ce_n),
      .token_space_select_n_out(sel_n), .oe_n_out(oe_n), .rw_n_out(rw_n), .addr_out(addr),
      .data_out(data_out), .data_oe_out(data_oe), .data_in(data_in));
   dpsf_dev_model #(.INIT_REQ_A(INIT_A), .INIT_REQ_B(INIT_B)) dpsf_dev_model_inst (
      .sys_clk_in(sys_clk_in), .a_ce_n_in(ce_n), .a_sel_n_in(sel_n), .a_oe_n_in(oe_n),
      .a_rw_n_in(rw_n), .a_addr_in(addr), .a_data_in(data_in), .a_data_out(dev_data),
      .b_sel_n_in(b_sel_n), .b_oe_n_in(b_oe_n), .b_rw_n_in(b_rw_n), .b_idx_in(b_idx),
      .b_data_in(b_wdata), .b_data_out(b_rdata));
   task automatic print_verdict();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
      cmp_count++;
      if (got_v !== exp_v) begin
         errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got_v, exp_v);
      end
   endtask : check
   // reference: a write sets a latch, then ownership is resolved
   task automatic ref_write(input int p, input int i, input bit v);
      if (p == 1) req_a[i] = v;
      else req_b[i] = v;
      if (own[i] == 1 && req_a[i]) own[i] = req_b[i] ? 0 : 2;
      else if (own[i] == 2 && req_b[i]) own[i] = req_a[i] ? 0 : 1;
      if (own[i] == 0) own[i] = !req_a[i] ? 1 : (!req_b[i] ? 2 : 0);
   endtask : ref_write
   // one command, entered and left at a falling edge
   task automatic do_cmd(input dpsf_op_t op, input int i);
      int n;
      n = 0;
      while (cmd_ready_out !== 1'b1 && n < 300) begin
         @(negedge sys_clk_in);
         n++;
      end
      check(cmd_ready_out, 1'b1);
      cmd_valid_in = 1'b1;
      cmd_in = '{op: op, idx: i[2:0]};
      @(negedge sys_clk_in);
      cmd_valid_in = 1'b0;
      n = 0;
      while (rsp_valid_out !== 1'b1 && n < 300) begin
         @(negedge sys_clk_in);
         n++;
      end
      check(rsp_valid_out, 1'b1);
      got = rsp_out;
      @(negedge sys_clk_in);
   endtask : do_cmd
   // far-port access; select drops between accesses so reads re-latch
   task automatic b_acc(input int i, input bit wr, input bit v);
      b_idx = i[2:0];
      b_wdata = {8'($urandom), v};
      b_sel_n = 1'b0;
      b_rw_n = !wr;
      b_oe_n = wr;
      repeat (3) @(negedge sys_clk_in);
      b_got = b_rdata;
      b_sel_n = 1'b1;
      b_rw_n = 1'b1;
      b_oe_n = 1'b1;
      repeat (2) @(negedge sys_clk_in);
      if (wr) ref_write(2, i, v);
   endtask : b_acc
   task automatic b_read(input int i);
      b_acc(i, 1'b0, 1'b0);
      check(b_got, {9{own[i] != 2}});
   endtask : b_read
   task automatic a_acq(input int i);
      bit ok;
      ref_write(1, i, 0);
      ok = (own[i] == 1);
      if (!ok) ref_write(1, i, 1);
      do_cmd(DPSF_OP_ACQUIRE, i);
      check(got, {ok, !ok, !ok});
   endtask : a_acq
   task automatic a_peek(input int i);
      do_cmd(DPSF_OP_PEEK, i);
      check(got.flag, own[i] != 1);
      check(ce_n, 1'b1);
      // idle pins after an access: strobes and select all released
      check({oe_n, rw_n, sel_n}, 3'h7);
      // only the flag index rides the address, upper lines held low
      check(addr, i);
   endtask : a_peek
   task automatic a_rel(input int i);
      ref_write(1, i, 1);
      do_cmd(DPSF_OP_RELEASE, i);
      // the release puts a one on every data line, then lets go of them
      check({data_oe, data_out}, 10'h1ff);
   endtask : a_rel
   task automatic do_reset();
      sys_rst_in = 1'b1;
      repeat (16) @(negedge sys_clk_in);
      check({sel_n, cmd_ready_out, data_oe}, 3'b100);
      sys_rst_in = 1'b0;
      for (int i = 0; i < 8; i++) ref_write(1, i, 1);
   endtask : do_reset
   initial begin
      #400us;
      errors++;
      print_verdict();
   end
   initial begin
      f = $urandom(1);
      for (int i = 0; i < 8; i++) begin
         req_a[i] = INIT_A[i];
         req_b[i] = INIT_B[i];
         own[i] = !req_a[i] ? 1 : (!req_b[i] ? 2 : 0);
      end
      do_reset();
      // stale far-port requests survive power-up until written one
      for (int i = 0; i < 8; i++) begin
         a_peek(i);
         b_read(i);
         b_acc(i, 1'b1, 1'b1);
      end
      for (int n = 0; n < 8; n++) begin
         f = int'($urandom_range(7, 0));
         a_acq(f);
         a_peek(f);
         b_acc(f, 1'b1, 1'b0);
         b_read(f);
         a_rel(f);
         b_read(f);
         a_peek(f);
         a_acq(f);
         b_acc(f, 1'b1, 1'b1);
         b_read(f);
         a_peek(f);
      end
      // competing requests at shifting offsets: exactly one owner
      for (int k = 0; k < 6; k++) begin
         fork
            do_cmd(DPSF_OP_ACQUIRE, k);
            begin
               repeat (k) @(negedge sys_clk_in);
               b_acc(k, 1'b1, 1'b0);
            end
         join
         g = got.granted;
         req_a[k] = !g;
         own[k] = g ? 1 : 2;
         check(got.withdrawn, !g);
         // both zeros land on one edge at k == 3, so that tie may go either way
         if (k != 3) check(g, k > 3);
         b_read(k);
         a_rel(k);
         b_acc(k, 1'b1, 1'b1);
         a_peek(k);
      end
      // init command and a second reset both free the controller side
      b_acc(2, 1'b1, 1'b0);
      a_acq(5);
      for (int i = 0; i < 8; i++) ref_write(1, i, 1);
      do_cmd(DPSF_OP_INIT, 0);
      a_peek(5);
      b_read(2);
      b_acc(2, 1'b1, 1'b1);
      a_acq(4);
      do_reset();
      a_peek(4);
      print_verdict();
   end
endmodule : tb_dpsf_host
